//--- core/pdsc_ctrl.sv
// Function
// - Five states: reset, detect, class, idle, on
// - Reset state disables resistors, pass transistor, maintain-power signature; clears classification
// - Below reset floor: reset, power off
// - Detection connects signature resistor
// - Signature resistor released after detection
// - Class window terminated in class resistor
// - Accept one- and two-event classification
// - Class resistor released after classification
// - Idle with monitoring only until full power
// - On-level input enters on, enables converter
// - On state presents maintain-power signature
// - Undervoltage turns pass transistor off
// - Limit select picks 350 or 720 mA; 720 mA only while the type 2 capable control bit is set
// - Local power ignores current limit select
// - Thermal shutdown at hot, restore when cool
// - Indicator low in reset, detect, class unless local power is detected
// - Indicator high after two-event classification
// - Indicator held until reset or power-down
// - Type 1 source keeps indicator low unless local power is detected
// - Local power turns pass transistor off
// - Indicator also readable as register bit
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "pdsc_defs.svh"

module pdsc_ctrl
  import pdsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PDSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vin_above_reset,
  input wire logic vin_in_class,
  input wire logic vin_in_mark,
  input wire logic vin_above_class,
  input wire logic vin_on_level,
  input wire logic uvlo_low,
  input wire logic over_current,
  input wire logic temp_hot,
  input wire logic temp_cool,
  input wire logic local_power_detect,
  input wire logic current_limit_select,
  output logic signature_resistor_pin_en,
  output logic class_resistor_en,
  output logic pass_fet_on,
  output logic pass_fet_throttle,
  output logic current_limit_high,
  output logic cable_limit_active,
  output logic mps_enable,
  output logic dcdc_enable,
  output logic monitor_only,
  output logic thermal_shutdown,
  output logic type2_power_indicator
);

  // ****************************************************************
  // Flag synchronisation
  // ****************************************************************
  pdsc_sync_if flag_bus ();
  logic [`PDSC_NFLAG-1:0] s;
  logic vin_mark_w;

  assign flag_bus.raw = {current_limit_select, local_power_detect, temp_cool, temp_hot,
                         over_current, uvlo_low, vin_on_level, vin_above_class,
                         vin_mark_w, vin_in_class, vin_above_reset};
  assign vin_mark_w = vin_in_mark;
  assign s = flag_bus.sync;

  pdsc_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .flags(flag_bus.dst)
  );

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [31:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] status_w;
  logic setup_w;
  logic access_w;
  logic mapped_w;
  pdsc_state_t state_ff;
  logic type2_ff;
  logic therm_ff;
  logic ind_ff;
  logic pass_ff;
  logic limhi_ff;

  assign setup_w = psel && !penable;
  assign access_w = psel && penable && pready_ff;
  assign mapped_w = (paddr == `PDSC_OFS_CTRL) || (paddr == `PDSC_OFS_STATUS);

  always_comb begin
    status_w = '0;
    status_w[`PDSC_ST_STATE_LSB +: 3] = state_ff;
    status_w[`PDSC_ST_TYPE2] = ind_ff;
    status_w[`PDSC_ST_THERM] = therm_ff;
    status_w[`PDSC_ST_PASS] = pass_ff;
    status_w[`PDSC_ST_LOCAL] = s[`PDSC_F_LOCAL];
    status_w[`PDSC_ST_LIMHI] = limhi_ff;
  end

  // Zero-wait slave: data and error settle in setup, ready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup_w;
      pslverr_ff <= setup_w && !mapped_w;
      if (setup_w && !pwrite) begin
        if (paddr == `PDSC_OFS_CTRL) begin
          prdata_ff <= ctrl_ff;
        end else if (paddr == `PDSC_OFS_STATUS) begin
          prdata_ff <= status_w;
        end else begin
          prdata_ff <= 32'h00000000;
        end
      end
    end
  end

  // Only two control bits are kept; the rest read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `PDSC_CTRL_RESET;
    end else if (access_w && pwrite && paddr == `PDSC_OFS_CTRL) begin
      ctrl_ff <= {30'h00000000, pwdata[1:0]};
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************************************
  // Operating state machine
  // ****************************************************************
  pdsc_state_t nxt_state;
  logic [1:0] events_ff;
  logic mark_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PDSC_RESET: begin
        if (s[`PDSC_F_ABOVE_RESET]) nxt_state = PDSC_DETECT;
      end
      PDSC_DETECT: begin
        if (s[`PDSC_F_IN_CLASS]) nxt_state = PDSC_CLASS;
        else if (s[`PDSC_F_ABOVE_CLASS]) nxt_state = PDSC_IDLE;
      end
      PDSC_CLASS: begin
        if (s[`PDSC_F_ABOVE_CLASS]) nxt_state = PDSC_IDLE;
      end
      PDSC_IDLE: begin
        if (s[`PDSC_F_ON_LEVEL]) nxt_state = PDSC_ON;
      end
      PDSC_ON: begin
        // Dropping out of on is the power-down event
        if (s[`PDSC_F_UVLO]) nxt_state = PDSC_IDLE;
      end
      default: nxt_state = PDSC_RESET;
    endcase
    if (!s[`PDSC_F_ABOVE_RESET]) nxt_state = PDSC_RESET;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PDSC_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Class event counter; a class window that follows a mark is event two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_ff <= 2'h0;
      mark_ff <= 1'b0;
    end else if (state_ff == PDSC_RESET) begin
      events_ff <= 2'h0;
      mark_ff <= 1'b0;
    end else if (state_ff == PDSC_DETECT && nxt_state == PDSC_CLASS) begin
      events_ff <= 2'h1;
      mark_ff <= 1'b0;
    end else if (state_ff == PDSC_CLASS) begin
      if (s[`PDSC_F_IN_MARK]) mark_ff <= 1'b1;
      if (mark_ff && s[`PDSC_F_IN_CLASS]) events_ff <= 2'h2;
    end
  end

  // ****************************************************************
  // Type 2 indication
  // ****************************************************************
  logic t2_set_w;
  logic t2_clr_w;

  assign t2_set_w = state_ff == PDSC_CLASS && nxt_state == PDSC_IDLE && events_ff == 2'h2
                    && ctrl_ff[`PDSC_CTRL_TYPE2_CAP];
  assign t2_clr_w = state_ff == PDSC_RESET || (state_ff == PDSC_ON && s[`PDSC_F_UVLO]);

  // Set wins over clear so a completing classification is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type2_ff <= 1'b0;
    end else if (t2_set_w) begin
      type2_ff <= 1'b1;
    end else if (t2_clr_w) begin
      type2_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_ff <= 1'b0;
    end else begin
      ind_ff <= s[`PDSC_F_LOCAL] || type2_ff;
    end
  end

  // ****************************************************************
  // Thermal hysteresis
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_ff <= 1'b0;
    end else if (s[`PDSC_F_TEMP_HOT]) begin
      therm_ff <= 1'b1;
    end else if (s[`PDSC_F_TEMP_COOL]) begin
      therm_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Power path outputs
  // ****************************************************************
  logic sig_ff;
  logic cls_ff;
  logic thr_ff;
  logic climact_ff;
  logic mps_ff;
  logic dcdc_ff;
  logic mon_ff;
  logic fet_ok_w;

  assign fet_ok_w = state_ff == PDSC_ON && !s[`PDSC_F_UVLO] && !therm_ff
                    && !s[`PDSC_F_LOCAL] && !ctrl_ff[`PDSC_CTRL_SW_OFF];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_ff <= 1'b0;
      cls_ff <= 1'b0;
      pass_ff <= 1'b0;
      thr_ff <= 1'b0;
      mps_ff <= 1'b0;
      dcdc_ff <= 1'b0;
      mon_ff <= 1'b0;
    end else begin
      sig_ff <= state_ff == PDSC_DETECT;
      cls_ff <= state_ff == PDSC_CLASS && s[`PDSC_F_IN_CLASS];
      pass_ff <= fet_ok_w;
      thr_ff <= fet_ok_w && s[`PDSC_F_OVER_CUR];
      mps_ff <= state_ff == PDSC_ON;
      // Local supply feeds the converter directly, still under thermal guard
      dcdc_ff <= !therm_ff && (fet_ok_w || s[`PDSC_F_LOCAL]);
      mon_ff <= state_ff == PDSC_IDLE;
    end
  end

  // Cable limit only matters while cable power is in use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      climact_ff <= 1'b0;
      limhi_ff <= 1'b0;
    end else begin
      climact_ff <= !s[`PDSC_F_LOCAL];
      limhi_ff <= !s[`PDSC_F_LOCAL] && s[`PDSC_F_LIMIT_SEL]
                  && ctrl_ff[`PDSC_CTRL_TYPE2_CAP];
    end
  end

  assign signature_resistor_pin_en = sig_ff;
  assign class_resistor_en = cls_ff;
  assign pass_fet_on = pass_ff;
  assign pass_fet_throttle = thr_ff;
  assign current_limit_high = limhi_ff;
  assign cable_limit_active = climact_ff;
  assign mps_enable = mps_ff;
  assign dcdc_enable = dcdc_ff;
  assign monitor_only = mon_ff;
  assign thermal_shutdown = therm_ff;
  assign type2_power_indicator = ind_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_entry: assert property (
    !s[`PDSC_F_ABOVE_RESET] |=> state_ff == PDSC_RESET ##1 !pass_ff && !mps_ff && !type2_ff)
    else $error("low input did not force reset and power off");
  a_reset_quiet: assert property (
    state_ff == PDSC_RESET |=> !sig_ff && !cls_ff && !pass_ff && !mps_ff && events_ff == 2'h0)
    else $error("circuitry active in reset");
  a_sig_window: assert property (
    state_ff == PDSC_DETECT |=> sig_ff)
    else $error("signature resistor not connected in detection");
  a_sig_release: assert property (
    $fell(state_ff == PDSC_DETECT) |=> !sig_ff)
    else $error("signature resistor kept after detection");
  a_class_term: assert property (
    state_ff == PDSC_CLASS && s[`PDSC_F_IN_CLASS] |=> cls_ff)
    else $error("class window not terminated");
  a_class_release: assert property (
    state_ff == PDSC_IDLE |=> !cls_ff ##1 !cls_ff)
    else $error("class resistor kept after classification");
  a_on_entry: assert property (
    state_ff == PDSC_IDLE && s[`PDSC_F_ON_LEVEL] && s[`PDSC_F_ABOVE_RESET]
    |=> state_ff == PDSC_ON ##1 mps_ff)
    else $error("on level did not enter on state");
  a_uvlo_off: assert property (
    s[`PDSC_F_UVLO] |=> !pass_ff)
    else $error("pass transistor on under undervoltage");
  a_local_path: assert property (
    s[`PDSC_F_LOCAL] |=> !pass_ff && ind_ff && !limhi_ff && !climact_ff)
    else $error("local power handling wrong");
  a_thermal_trip: assert property (
    s[`PDSC_F_TEMP_HOT] |=> therm_ff ##1 !pass_ff && !dcdc_ff)
    else $error("thermal shutdown missed");
  a_type1_low: assert property (
    state_ff == PDSC_CLASS && nxt_state == PDSC_IDLE && events_ff == 2'h1 && !type2_ff
    |=> !type2_ff)
    else $error("single event classification raised indicator");
  a_type2_hold: assert property (
    type2_ff && state_ff == PDSC_IDLE && s[`PDSC_F_ABOVE_RESET] |=> type2_ff)
    else $error("indicator dropped without reset or power-down");
  a_type2_rise: assert property (
    t2_set_w && !s[`PDSC_F_LOCAL] |=> type2_ff ##1 ind_ff)
    else $error("indicator not raised after two events");

  c_reach_on: cover property (state_ff == PDSC_IDLE ##1 state_ff == PDSC_ON);
  c_type2: cover property ($rose(type2_ff));
  c_thermal: cover property ($rose(therm_ff) ##[1:20] $fell(therm_ff));
  c_apb_read: cover property (access_w && !pwrite && paddr == `PDSC_OFS_STATUS);

endmodule

//--- core/pdsc_defs.svh
`ifndef PDSC_DEFS_SVH
`define PDSC_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PDSC_ADDR_W 8
`define PDSC_OFS_CTRL 8'h00
`define PDSC_OFS_STATUS 8'h04
`define PDSC_CTRL_RESET 32'h00000001
`define PDSC_CTRL_TYPE2_CAP 0
`define PDSC_CTRL_SW_OFF 1
`define PDSC_ST_STATE_LSB 0
`define PDSC_ST_TYPE2 4
`define PDSC_ST_THERM 5
`define PDSC_ST_PASS 6
`define PDSC_ST_LOCAL 7
`define PDSC_ST_LIMHI 8

// ****************************************************************
// Comparator flag positions
// ****************************************************************
`define PDSC_NFLAG 11
`define PDSC_F_ABOVE_RESET 0
`define PDSC_F_IN_CLASS 1
`define PDSC_F_IN_MARK 2
`define PDSC_F_ABOVE_CLASS 3
`define PDSC_F_ON_LEVEL 4
`define PDSC_F_UVLO 5
`define PDSC_F_OVER_CUR 6
`define PDSC_F_TEMP_HOT 7
`define PDSC_F_TEMP_COOL 8
`define PDSC_F_LOCAL 9
`define PDSC_F_LIMIT_SEL 10

`endif

//--- core/pdsc_pkg.sv
package pdsc_pkg;
  typedef enum logic [2:0] {
    PDSC_RESET,
    PDSC_DETECT,
    PDSC_CLASS,
    PDSC_IDLE,
    PDSC_ON
  } pdsc_state_t;
endpackage

//--- core/pdsc_sync_if.sv
`timescale 1ns/1ps
`include "pdsc_defs.svh"

interface pdsc_sync_if;
  logic [`PDSC_NFLAG-1:0] raw;
  logic [`PDSC_NFLAG-1:0] sync;
  modport src(output raw, input sync);
  modport dst(input raw, output sync);
endinterface

//--- core/pdsc_sync2.sv
`timescale 1ns/1ps
`include "pdsc_defs.svh"

// ****************************************************************
// Two-stage synchroniser for the comparator flags
// ****************************************************************
module pdsc_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  pdsc_sync_if.dst flags
);
  logic [`PDSC_NFLAG-1:0] meta_ff;
  logic [`PDSC_NFLAG-1:0] sync_ff;

  // First stage is read only by the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= flags.raw;
      sync_ff <= meta_ff;
    end
  end

  assign flags.sync = sync_ff;
endmodule

//--- tb/pdsc_pse_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Sourcing equipment: line level seen as comparator flags
// ****************************************************************
module pdsc_pse_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] lvl,
  input wire logic slow,
  input wire logic mps,
  output logic vin_above_reset,
  output logic vin_in_class,
  output logic vin_in_mark,
  output logic vin_above_class,
  output logic vin_on_level,
  output logic uvlo_low
);
  logic [2:0] cur_ff;
  logic [3:0] lag_ff;
  logic [3:0] lost_ff;

  // Slow mode lags each level step, like a source with long ramps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= 3'h0;
      lag_ff <= 4'h0;
      lost_ff <= 4'h0;
    end else begin
      lag_ff <= (cur_ff != lvl) ? lag_ff + 4'h1 : 4'h0;
      lost_ff <= (cur_ff == 3'h5 && !mps) ? lost_ff + 4'h1 : 4'h0;
      if (lost_ff == 4'hf) begin
        cur_ff <= 3'h0;
      end else if (cur_ff != lvl && (!slow || lag_ff == 4'h3)) begin
        cur_ff <= lvl;
      end
    end
  end

  assign vin_above_reset = (cur_ff != 3'h0);
  assign vin_in_class = (cur_ff == 3'h2);
  assign vin_in_mark = (cur_ff == 3'h3);
  assign vin_above_class = (cur_ff >= 3'h4);
  assign vin_on_level = (cur_ff == 3'h5);
  assign uvlo_low = (cur_ff != 3'h5);
endmodule

//--- tb/tb_poe_powered_device_state_control.sv
`timescale 1ns/1ps
`include "pdsc_defs.svh"

// ****************************************************************
// Bench with a reference model of the state flow
// ****************************************************************
module tb_poe_powered_device_state_control;
  import pdsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, v_ar, v_ic, v_im, v_ac, v_on, uvlo;
  logic ovc = 1'b0, hot = 1'b0, cool = 1'b0, loc = 1'b0, lim_sel = 1'b0, slow = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic sig, cls, pass, thr, limh, cab, mps, dcdc, mon, thsd, t2;
  int err_count = 0, n_checks = 0;
  int st = 0, ev = 0, t2m = 0, th = 0, sw = 0, lv = 0, cap = 1;
  int exp_q[$];

  always #5 pclk = ~pclk;

  pdsc_pse_model pse (.pclk(pclk), .presetn(presetn), .lvl(lvl), .slow(slow), .mps(mps),
    .vin_above_reset(v_ar), .vin_in_class(v_ic), .vin_in_mark(v_im),
    .vin_above_class(v_ac), .vin_on_level(v_on), .uvlo_low(uvlo));

  pdsc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vin_above_reset(v_ar), .vin_in_class(v_ic), .vin_in_mark(v_im),
    .vin_above_class(v_ac), .vin_on_level(v_on), .uvlo_low(uvlo), .over_current(ovc),
    .temp_hot(hot), .temp_cool(cool), .local_power_detect(loc),
    .current_limit_select(lim_sel), .signature_resistor_pin_en(sig), .class_resistor_en(cls),
    .pass_fet_on(pass), .pass_fet_throttle(thr), .current_limit_high(limh),
    .cable_limit_active(cab), .mps_enable(mps), .dcdc_enable(dcdc), .monitor_only(mon),
    .thermal_shutdown(thsd), .type2_power_indicator(t2));

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] seen, input int exp);
    n_checks++;
    if (seen !== 32'(exp)) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input int x, input int xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp("rdata", r, x);
    cmp("slverr", {31'h0, e}, xe);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp("wr_slverr", {31'h0, e}, xe);
  endtask

  task automatic chk();
    int px;
    int lh;
    px = (st == 4) && (lv == 5) && !loc && !th && !sw;
    lh = !loc && lim_sel && cap;
    cmp("sig_en", sig, st == 1);
    cmp("class_en", cls, st == 2 && lv == 2);
    cmp("monitor", mon, st == 3);
    cmp("mps", mps, st == 4);
    cmp("pass_fet", pass, px);
    cmp("throttle", thr, px && ovc);
    cmp("limit_high", limh, lh);
    cmp("cable_limit", cab, !loc);
    cmp("dcdc", dcdc, !th && (px || loc));
    cmp("thermal", thsd, th);
    cmp("indicator", t2, loc || t2m);
    exp_q.push_back(st | (loc || t2m) << 4 | th << 5 | px << 6 | loc << 7 | lh << 8);
    rd(`PDSC_OFS_STATUS, exp_q.pop_front(), 0);
  endtask

  task automatic settle();
    repeat (12) @(posedge pclk);
    #1;
    chk();
  endtask

  task automatic go(input int l);
    if (l == 0) begin
      st = 0;
      ev = 0;
      t2m = 0;
    end else if (l == 1 && st == 0) begin
      st = 1;
    end else if (l == 2 && st inside {1, 2}) begin
      st = 2;
      ev++;
    end else if (l == 4 && st inside {1, 2}) begin
      st = 3;
      t2m = (ev >= 2) && cap;
    end else if (l == 4 && st == 4) begin
      st = 3;
      t2m = 0;
    end else if (l == 5 && st == 3) begin
      st = 4;
    end
    lv = l;
    lvl <= 3'(l);
    settle();
  endtask

  initial begin
    void'($urandom(49009));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    rd(`PDSC_OFS_CTRL, 1, 0);
    rd(8'h08, 0, 1);
    wr(8'h08, 32'hffffffff, 1);
    wr(`PDSC_OFS_STATUS, 32'hffffffff, 0);
    rd(`PDSC_OFS_STATUS, 0, 0);
    for (int k = 0; k < 3; k++) begin
      slow <= 1'(k == 1);
      if (k == 2) begin
        wr(`PDSC_OFS_CTRL, 32'h0, 0);
        cap = 0;
      end
      go(1);
      go(2);
      if (k != 1) begin
        go(3);
        go(2);
      end
      go(4);
      go(5);
      if (k == 0) begin
        for (int i = 0; i < 8; i++) begin
          ovc <= 1'($urandom % 2);
          lim_sel <= 1'($urandom % 2);
          settle();
        end
        hot <= 1'b1;
        th = 1;
        settle();
        hot <= 1'b0;
        settle();
        cool <= 1'b1;
        th = 0;
        settle();
        cool <= 1'b0;
        wr(`PDSC_OFS_CTRL, 32'h3, 0);
        sw = 1;
        settle();
        wr(`PDSC_OFS_CTRL, 32'h1, 0);
        sw = 0;
        settle();
        go(4);
      end else begin
        loc <= 1'b1;
        settle();
        loc <= 1'b0;
        settle();
      end
      go(0);
    end
    test_done();
  end
endmodule
